// [rtl/flash_gate_pkg.sv]
// Shared constants and carrier types for the flash access security gate
package flash_gate_pkg;
	localparam logic [15:0] VEC_TOP_LO      = 16'hffe0;
	localparam logic [15:0] VEC_TOP_HI      = 16'hffff;
	localparam logic [15:0] ERASE_OPT_ADDR  = 16'hfffa;
	localparam logic [15:0] DEBUG_OPT_ADDR  = 16'hfffb;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam logic [15:0] PTR_LO          = 16'h8000;
	localparam logic [15:0] PTR_HI          = 16'hfeff;
	localparam logic [15:0] PCMP_LIMIT      = 16'hff00;
	localparam logic [7:0]  MIN_COUNT       = 8'h08;
	localparam logic [7:0]  HEX_START_MARK  = 8'h3a;
	localparam logic [7:0]  CMD_ERASE       = 8'hf0;
	localparam logic [7:0]  CMD_WRITE       = 8'h30;
	localparam logic [7:0]  CMD_READ        = 8'h40;
	localparam logic [7:0]  CMD_RAM_LOAD    = 8'h60;
	localparam logic [7:0]  CMD_SECURITY    = 8'hfa;
	localparam logic [7:0]  CMD_STATUS      = 8'hc3;

	// Command request from the serial command framer
	typedef struct packed {
		logic [7:0] opcode;
		logic       chip_erase;
	} cmd_req_t;

	// Pointer pair received after the command
	typedef struct packed {
		logic [15:0] password_length_pointer;
		logic [15:0] compare_start_pointer;
	} ptr_pair_t;

	// Flash read port
	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} flash_rd_t;
endpackage

// [rtl/vector_scanner.sv]
// Scans the top vector range for blank state and option bytes
`timescale 1ns/10ps
`default_nettype none
module vector_scanner
	import flash_gate_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        start_i,
	output logic             rd_req_o,
	output logic [15:0]      rd_addr_o,
	input  wire logic        rd_valid_i,
	input  wire logic [7:0]  rd_data_i,
	output logic             done_o,
	output logic             blank_o,
	output logic             erase_bypass_o,
	output logic             debug_bypass_o
);
	logic        busy_q;
	logic        wait_q;
	logic [15:0] addr_q;

	assign rd_req_o  = busy_q && !wait_q;
	assign rd_addr_o = addr_q;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			busy_q <= 1'b0;
			wait_q <= 1'b0;
			addr_q <= VEC_TOP_LO;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_q) begin
				busy_q <= 1'b1;
				addr_q <= VEC_TOP_LO;
			end else if (busy_q && !wait_q) begin
				wait_q <= 1'b1;
			end else if (busy_q && rd_valid_i) begin
				wait_q <= 1'b0;
				if (addr_q == VEC_TOP_HI) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
				end else begin
					addr_q <= addr_q + 16'h0001;
				end
			end
		end
	end

	// Fresh classification on every scan, never cached across commands
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			blank_o        <= 1'b1;
			erase_bypass_o <= 1'b1;
			debug_bypass_o <= 1'b1;
		end else if (start_i && !busy_q) begin
			blank_o <= 1'b1;
		end else if (busy_q && wait_q && rd_valid_i) begin
			if (rd_data_i != ERASED_BYTE)
				blank_o <= 1'b0;
			if (addr_q == ERASE_OPT_ADDR)
				erase_bypass_o <= (rd_data_i == ERASED_BYTE);
			if (addr_q == DEBUG_OPT_ADDR)
				debug_bypass_o <= (rd_data_i == ERASED_BYTE);
		end
	end
endmodule
`default_nettype wire

// [rtl/repeat_detector.sv]
// Flags three identical bytes in a row within a byte stream
`timescale 1ns/10ps
`default_nettype none
module repeat_detector (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire logic       clear_i,
	input  wire logic       valid_i,
	input  wire logic [7:0] data_i,
	output logic            repeat_o
);
	logic [7:0] last_q;
	logic [1:0] run_q;
	logic       any_q;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || clear_i) begin
			last_q   <= 8'h00;
			run_q    <= 2'h0;
			any_q    <= 1'b0;
			repeat_o <= 1'b0;
		end else if (valid_i) begin
			any_q  <= 1'b1;
			last_q <= data_i;
			if (any_q && data_i == last_q) begin
				run_q <= (run_q == 2'h2) ? 2'h2 : run_q + 2'h1;
				if (run_q != 2'h0)
					repeat_o <= 1'b1;
			end else begin
				run_q <= 2'h0;
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/flash_access_security_gate.sv]
// Flash access security gate: authentication, lock and option byte control
`timescale 1ns/10ps
`default_nettype none
module flash_access_security_gate
	import flash_gate_pkg::*;
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    reset_i,
	input  wire logic                    cmd_valid_i,
	input  wire flash_gate_pkg::cmd_req_t cmd_i,
	input  wire logic                    ptr_valid_i,
	input  wire flash_gate_pkg::ptr_pair_t ptr_i,
	input  wire logic                    rx_valid_i,
	input  wire logic [7:0]              rx_data_i,
	input  wire logic                    debug_start_i,
	input  wire logic                    par_mode_i,
	input  wire logic                    par_read_i,
	input  wire logic                    par_write_i,
	input  wire logic                    par_chip_erase_i,
	input  wire logic                    op_done_i,
	input  wire logic                    lock_nv_i,
	input  wire logic                    flash_rd_valid_i,
	input  wire logic [7:0]              flash_rd_data_i,
	output flash_gate_pkg::flash_rd_t    flash_rd_o,
	output logic                         exec_o,
	output logic [7:0]                   exec_cmd_o,
	output logic                         exec_chip_erase_o,
	output logic                         hex_rx_en_o,
	output logic                         hex_rx_valid_o,
	output logic [7:0]                   hex_rx_data_o,
	output logic                         lock_set_o,
	output logic                         lock_clear_o,
	output logic                         debug_grant_o,
	output logic                         par_read_ok_o,
	output logic                         par_write_ok_o,
	output logic                         par_erase_ok_o,
	output logic                         status_blank_o,
	output logic                         idle_o,
	output logic                         pw_error_o
);
	typedef enum logic [3:0] {
		S_READY, S_SCAN, S_WAIT_PTR, S_RD_CNT, S_CHECK, S_STRING,
		S_CMP_RD, S_GRANT, S_HEX_HUNT, S_BUSY, S_DEAD
	} state_t;

	state_t      state_q;
	cmd_req_t    cmd_q;
	logic        debug_q;
	logic [15:0] len_ptr_q;
	logic [15:0] cmp_ptr_q;
	logic [7:0]  count_q;
	logic [7:0]  idx_q;
	logic [7:0]  rx_byte_q;
	logic        rd_wait_q;
	flash_rd_t   rd_next;
	logic        scan_done;
	logic        scan_rd_req;
	logic [15:0] scan_rd_addr;
	logic        blank;
	logic        erase_bypass;
	logic        debug_bypass;
	logic        repeat_hit;
	logic        str_byte;
	logic        needs_string;
	logic        range_ok;

	function automatic logic in_window(input logic [15:0] a, input logic [15:0] hi);
		in_window = (a >= PTR_LO) && (a <= hi);
	endfunction

	function automatic logic is_protected(input logic [7:0] op);
		is_protected = (op == CMD_ERASE) || (op == CMD_WRITE) || (op == CMD_READ) ||
			(op == CMD_RAM_LOAD) || (op == CMD_SECURITY);
	endfunction

	assign str_byte   = (state_q == S_STRING) && rx_valid_i;

	// String is skipped on a blank part, or by a non-debug chip erase under the bypass byte
	always_comb begin
		if (blank)
			needs_string = 1'b0;
		else if (!debug_q && cmd_q.opcode == CMD_ERASE && erase_bypass && cmd_q.chip_erase)
			needs_string = 1'b0;
		else
			needs_string = 1'b1;
	end

	// Range check of pointers and count
	always_comb begin
		range_ok = in_window(len_ptr_q, PTR_HI);
		if (blank)
			range_ok = range_ok && in_window(cmp_ptr_q, PTR_HI);
		else
			range_ok = range_ok && (count_q >= MIN_COUNT) &&
				in_window(cmp_ptr_q, PCMP_LIMIT - {8'h00, count_q});
	end

	logic scan_go_q;

	vector_scanner u_scan (
		.ref_clk_i      (ref_clk_i),
		.reset_i        (reset_i),
		.start_i        (scan_go_q),
		.rd_req_o       (scan_rd_req),
		.rd_addr_o      (scan_rd_addr),
		.rd_valid_i     (flash_rd_valid_i),
		.rd_data_i      (flash_rd_data_i),
		.done_o         (scan_done),
		.blank_o        (blank),
		.erase_bypass_o (erase_bypass),
		.debug_bypass_o (debug_bypass)
	);

	repeat_detector u_rep (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.clear_i   (state_q == S_CHECK),
		.valid_i   (str_byte),
		.data_i    (rx_data_i),
		.repeat_o  (repeat_hit)
	);

	// Main authentication sequence
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q    <= S_READY;
			cmd_q      <= '0;
			debug_q    <= 1'b0;
			len_ptr_q  <= 16'h0000;
			cmp_ptr_q  <= 16'h0000;
			count_q    <= 8'h00;
			idx_q      <= 8'h00;
			rx_byte_q  <= 8'h00;
			rd_wait_q  <= 1'b0;
			scan_go_q  <= 1'b0;
			pw_error_o <= 1'b0;
		end else begin
			scan_go_q <= 1'b0;
			unique case (state_q)
				S_READY: begin
					if (debug_start_i) begin
						debug_q   <= 1'b1;
						scan_go_q <= 1'b1;
						state_q   <= S_SCAN;
					end else if (cmd_valid_i && is_protected(cmd_i.opcode)) begin
						cmd_q     <= cmd_i;
						debug_q   <= 1'b0;
						// Of the commands, only chip erase may reach a locked part, it clears the lock
						if (lock_nv_i && !(cmd_i.opcode == CMD_ERASE && cmd_i.chip_erase))
							state_q <= S_DEAD;
						else begin
							scan_go_q <= 1'b1;
							state_q   <= S_SCAN;
						end
					end
				end
				S_SCAN: begin
					if (scan_done) begin
						if (debug_q && !debug_bypass && lock_nv_i)
							state_q <= S_DEAD;
						else if (debug_q)
							state_q <= blank ? S_GRANT : S_WAIT_PTR;
						else
							state_q <= S_WAIT_PTR;
					end
				end
				S_WAIT_PTR: begin
					if (ptr_valid_i) begin
						len_ptr_q <= ptr_i.password_length_pointer;
						cmp_ptr_q <= ptr_i.compare_start_pointer;
						rd_wait_q <= 1'b0;
						state_q   <= S_RD_CNT;
					end
				end
				S_RD_CNT: begin
					rd_wait_q <= 1'b1;
					if (!in_window(len_ptr_q, PTR_HI)) begin
						pw_error_o <= 1'b1;
						state_q    <= S_DEAD;
					end else if (rd_wait_q && flash_rd_valid_i) begin
						count_q <= flash_rd_data_i;
						state_q <= S_CHECK;
					end
				end
				S_CHECK: begin
					idx_q <= 8'h00;
					if (!range_ok) begin
						pw_error_o <= 1'b1;
						state_q    <= S_DEAD;
					end else if (!blank && cmd_q.opcode == CMD_ERASE && erase_bypass &&
							!cmd_q.chip_erase && !debug_q)
						state_q <= S_DEAD;
					else if (needs_string)
						state_q <= S_STRING;
					else if (!debug_q && (cmd_q.opcode == CMD_WRITE || cmd_q.opcode == CMD_RAM_LOAD))
						state_q <= S_HEX_HUNT;
					else
						state_q <= S_GRANT;
				end
				S_STRING: begin
					if (rx_valid_i) begin
						rx_byte_q <= rx_data_i;
						rd_wait_q <= 1'b0;
						state_q   <= S_CMP_RD;
					end
				end
				S_CMP_RD: begin
					rd_wait_q <= 1'b1;
					if (repeat_hit) begin
						pw_error_o <= 1'b1;
						state_q    <= S_DEAD;
					end else if (rd_wait_q && flash_rd_valid_i) begin
						if (flash_rd_data_i != rx_byte_q) begin
							pw_error_o <= 1'b1;
							state_q    <= S_DEAD;
						end else if (idx_q + 8'h01 == count_q)
							state_q <= S_GRANT;
						else begin
							idx_q   <= idx_q + 8'h01;
							state_q <= S_STRING;
						end
					end
				end
				S_GRANT: state_q <= S_BUSY;
				S_HEX_HUNT: begin
					if (rx_valid_i && rx_data_i == HEX_START_MARK)
						state_q <= S_BUSY;
				end
				S_BUSY: begin
					if (op_done_i && !debug_q)
						state_q <= S_READY;
				end
				S_DEAD: state_q <= S_DEAD;
				default: state_q <= S_DEAD;
			endcase
		end
	end

	// Flash read port shared by scanner, count fetch and compare
	always_comb begin
		rd_next.req  = scan_rd_req;
		rd_next.addr = scan_rd_addr;
		if (state_q == S_RD_CNT && !rd_wait_q) begin
			rd_next.req  = 1'b1;
			rd_next.addr = len_ptr_q;
		end else if (state_q == S_CMP_RD && !rd_wait_q) begin
			rd_next.req  = 1'b1;
			rd_next.addr = cmp_ptr_q + {8'h00, idx_q};
		end
	end

	// Registered port costs a cycle per read; every reader waits for valid anyway
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			flash_rd_o <= '0;
		else
			flash_rd_o <= rd_next;
	end

	// Grant strobes and lock control
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			exec_o            <= 1'b0;
			exec_cmd_o        <= 8'h00;
			exec_chip_erase_o <= 1'b0;
			lock_set_o        <= 1'b0;
			lock_clear_o      <= 1'b0;
			debug_grant_o     <= 1'b0;
		end else begin
			exec_o        <= 1'b0;
			lock_set_o    <= 1'b0;
			lock_clear_o  <= 1'b0;
			debug_grant_o <= 1'b0;
			if (state_q == S_GRANT || (state_q == S_HEX_HUNT && rx_valid_i &&
					rx_data_i == HEX_START_MARK)) begin
				if (debug_q)
					debug_grant_o <= 1'b1;
				else begin
					exec_o            <= 1'b1;
					exec_cmd_o        <= cmd_q.opcode;
					exec_chip_erase_o <= cmd_q.chip_erase;
					lock_set_o        <= (cmd_q.opcode == CMD_SECURITY);
					lock_clear_o      <= (cmd_q.opcode == CMD_ERASE) && cmd_q.chip_erase;
				end
			end
		end
	end

	// Hex record stream passes on once the start mark is found on a blank part; after a password grant it passes with no mark
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			hex_rx_en_o    <= 1'b0;
			hex_rx_valid_o <= 1'b0;
			hex_rx_data_o  <= 8'h00;
		end else begin
			hex_rx_en_o    <= (state_q == S_HEX_HUNT) || (state_q == S_BUSY &&
				(cmd_q.opcode == CMD_WRITE || cmd_q.opcode == CMD_RAM_LOAD) && !debug_q);
			hex_rx_valid_o <= rx_valid_i && ((state_q == S_HEX_HUNT &&
				rx_data_i == HEX_START_MARK) || (state_q == S_BUSY && hex_rx_en_o));
			hex_rx_data_o  <= rx_data_i;
		end
	end

	// Parallel mode gating, status and idle flags
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			par_read_ok_o  <= 1'b0;
			par_write_ok_o <= 1'b0;
			par_erase_ok_o <= 1'b0;
			status_blank_o <= 1'b1;
			idle_o         <= 1'b0;
		end else begin
			par_read_ok_o  <= par_mode_i && par_read_i && !lock_nv_i;
			par_write_ok_o <= par_mode_i && par_write_i && !lock_nv_i;
			par_erase_ok_o <= par_mode_i && par_chip_erase_i;
			if (scan_done)
				status_blank_o <= blank;
			idle_o <= (state_q == S_DEAD);
		end
	end
endmodule
`default_nettype wire

// [test/flash_gate_assertions.sv]
// Port checker for the flash access security gate
`timescale 1ns/10ps
`default_nettype none
module flash_gate_assertions
	import flash_gate_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       reset_i,
	input wire logic       par_mode_i,
	input wire logic       par_read_i,
	input wire logic       par_chip_erase_i,
	input wire logic       lock_nv_i,
	input wire logic       exec_o,
	input wire logic [7:0] exec_cmd_o,
	input wire logic       exec_chip_erase_o,
	input wire logic       hex_rx_en_o,
	input wire logic       hex_rx_valid_o,
	input wire logic [7:0] hex_rx_data_o,
	input wire logic       lock_set_o,
	input wire logic       debug_grant_o,
	input wire logic       par_read_ok_o,
	input wire logic       par_write_ok_o,
	input wire logic       par_erase_ok_o,
	input wire logic       idle_o,
	input wire logic       pw_error_o
);
	logic hex_seen_q;
	// Cleared with the enable so every record stream is judged afresh
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !hex_rx_en_o)
			hex_seen_q <= 1'b0;
		else if (hex_rx_valid_o)
			hex_seen_q <= 1'b1;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_dead;
		idle_o && pw_error_o;
	endsequence
	sequence s_par_open;
		par_mode_i && !lock_nv_i;
	endsequence
	idle_hold_a: assert property (idle_o |=> idle_o)
		else $error("idle left without reset");
	err_dead_a: assert property (s_dead |=> s_dead)
		else $error("error state not held");
	err_idle_a: assert property ($rose(pw_error_o) |-> ##[0:2] idle_o)
		else $error("password error without idle");
	idle_quiet_a: assert property (idle_o |-> !exec_o && !lock_set_o && !debug_grant_o)
		else $error("action while idle");
	lock_exec_a: assert property (exec_o && lock_nv_i |->
			exec_cmd_o == CMD_ERASE && exec_chip_erase_o)
		else $error("locked part executed a command");
	par_read_a: assert property (s_par_open ##0 par_read_i |=> par_read_ok_o)
		else $error("parallel read refused");
	par_lock_a: assert property (par_mode_i && lock_nv_i |=>
			!par_read_ok_o && !par_write_ok_o)
		else $error("parallel access while locked");
	par_erase_a: assert property (par_mode_i && par_chip_erase_i |=> par_erase_ok_o)
		else $error("parallel chip erase refused");
	hex_mark_a: assert property (hex_rx_valid_o && !hex_seen_q |->
			hex_rx_data_o == HEX_START_MARK)
		else $error("record stream began without start mark");
endmodule
bind flash_access_security_gate flash_gate_assertions u_chk (.*);
`default_nettype wire

// [test/flash_model.sv]
// Flash array model answering the gate's read port
`timescale 1ns/10ps
`default_nettype none
module flash_model
	import flash_gate_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire flash_rd_t  rd_i,
	input  wire logic [3:0] lat_i,
	output logic            valid_o,
	output logic [7:0]      data_o
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr_q;
	logic [3:0]  wait_q;
	logic        busy_q;
	initial begin
		foreach (mem[i]) mem[i] = ERASED_BYTE;
		valid_o = 1'b0;
		data_o = 8'h00;
		busy_q = 1'b0;
	end
	// Data toggles when not answering, so a stale byte never looks valid
	always @(posedge ref_clk_i) begin
		valid_o <= 1'b0;
		data_o <= ~data_o;
		if (rd_i.req) begin
			addr_q <= rd_i.addr;
			wait_q <= lat_i;
			busy_q <= 1'b1;
		end else if (busy_q && wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else if (busy_q) begin
			valid_o <= 1'b1;
			data_o <= mem[addr_q];
			busy_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the flash access security gate
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import flash_gate_pkg::*;
	logic      ref_clk_i, reset_i, cmd_valid_i, ptr_valid_i, rx_valid_i, debug_start_i;
	logic      par_mode_i, par_read_i, par_write_i, par_chip_erase_i, op_done_i, lock_nv_i;
	logic      flash_rd_valid_i, exec_o, exec_chip_erase_o, hex_rx_en_o, hex_rx_valid_o;
	logic      lock_set_o, lock_clear_o, debug_grant_o, par_read_ok_o, par_write_ok_o;
	logic      par_erase_ok_o, status_blank_o, idle_o, pw_error_o, exec_seen, set_seen, clr_seen;
	logic [3:0] lat;
	logic      exec_ce;
	logic [7:0] rx_data_i, flash_rd_data_i, exec_cmd_o, hex_rx_data_o, exec_op, hex_first;
	cmd_req_t  cmd_i;
	ptr_pair_t ptr_i;
	flash_rd_t flash_rd_o;
	int        error_cnt = 0;
	int        n_tests = 0;
	int        hex_cnt;
	flash_access_security_gate u_flash_access_security_gate (.*);
	flash_model u_flash (.ref_clk_i(ref_clk_i), .rd_i(flash_rd_o), .lat_i(lat),
		.valid_o(flash_rd_valid_i), .data_o(flash_rd_data_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (exec_o) begin
			exec_seen <= 1'b1;
			exec_op <= exec_cmd_o;
			exec_ce <= exec_chip_erase_o;
		end
		if (debug_grant_o) begin
			exec_seen <= 1'b1;
			exec_op <= 8'h00;
			exec_ce <= 1'b0;
		end
		if (lock_set_o)
			set_seen <= 1'b1;
		if (lock_clear_o)
			clr_seen <= 1'b1;
		if (hex_rx_valid_o && hex_cnt == 0)
			hex_first <= hex_rx_data_o;
		if (hex_rx_valid_o)
			hex_cnt <= hex_cnt + 1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic do_reset;
		reset_i = 1'b1;
		{exec_seen, set_seen, clr_seen} = 3'h0;
		hex_cnt = 0;
		tick(10);
		reset_i = 1'b0;
	endtask
	task automatic vec(input logic [7:0] b0, ea, db);
		u_flash.mem[VEC_TOP_LO] = b0;
		u_flash.mem[ERASE_OPT_ADDR] = ea;
		u_flash.mem[DEBUG_OPT_ADDR] = db;
	endtask
	task automatic set_pw(input logic [15:0] lp, cp, input logic [7:0] n, input logic rep);
		for (int k = 0; k < n; k++)
			u_flash.mem[cp + k] = rep ? 8'haa : 8'h11 + k[7:0];
		u_flash.mem[lp] = n;
	endtask
	// ok: 1 executes, 0 refused, 2 left open; op 0 starts the debug link
	task automatic run(input logic [7:0] op, input logic ce, input logic [15:0] lp, cp,
			input int n, bad, input logic [1:0] ok);
		int t;
		exec_seen = 1'b0;
		cmd_i = '{op, ce};
		cmd_valid_i = (op != 8'h00);
		debug_start_i = (op == 8'h00);
		tick(1);
		cmd_valid_i = 1'b0;
		debug_start_i = 1'b0;
		ptr_i = '{lp, cp};
		ptr_valid_i = 1'b1;
		// Pointers are held until the count read shows they were taken
		for (t = 0; t < 400 && !idle_o && !hex_rx_en_o && !exec_seen
				&& !(flash_rd_o.req && flash_rd_o.addr == lp); t++)
			tick(1);
		ptr_valid_i = 1'b0;
		for (int k = 0; k < n; k++) begin
			rx_data_i = u_flash.mem[cp + k] ^ ((k == bad) ? 8'h01 : 8'h00);
			rx_valid_i = 1'b1;
			for (t = 0; t < 400 && !idle_o
					&& !(flash_rd_o.req && flash_rd_o.addr == cp + k); t++)
				tick(1);
		end
		rx_valid_i = 1'b0;
		if (ok != 2'd2) begin
			for (t = 0; t < 400 && !exec_seen && !idle_o; t++)
				tick(1);
			chk(exec_seen, ok[0]);
			chk(idle_o, !ok[0]);
			if (ok[0]) begin
				chk(exec_op, op);
				chk(exec_ce, ce);
				op_done_i = 1'b1;
				tick(1);
				op_done_i = 1'b0;
				tick(2);
			end
		end
	endtask
	task automatic bad(input logic [15:0] lp, cp);
		do_reset();
		run(CMD_READ, 0, lp, cp, 8, -1, 0);
		chk(pw_error_o, 1);
	endtask
	task automatic t_par;
		par_mode_i = 1'b1;
		{par_read_i, par_write_i, par_chip_erase_i} = 3'h7;
		for (int l = 0; l < 2; l++) begin
			lock_nv_i = l[0];
			tick(2);
			chk(par_read_ok_o, !l[0]);
			chk(par_write_ok_o, !l[0]);
			chk(par_erase_ok_o, 1);
		end
		{par_mode_i, par_read_i, par_write_i, par_chip_erase_i, lock_nv_i} = 5'h0;
	endtask
	task automatic t_blank;
		logic [7:0] hx [3] = '{8'h55, HEX_START_MARK, 8'h10};
		do_reset();
		chk(status_blank_o, 1);
		run(CMD_ERASE, 1, 16'h8000, 16'h8000, 0, -1, 1);
		chk(status_blank_o, 1);
		run(8'h00, 0, 16'h8000, 16'h8000, 0, -1, 1);
		do_reset();
		run(CMD_WRITE, 0, 16'h8000, 16'hfeff, 0, -1, 2);
		for (int t = 0; t < 400 && !hex_rx_en_o; t++)
			tick(1);
		chk(hex_rx_en_o, 1);
		foreach (hx[i]) begin
			rx_data_i = hx[i];
			rx_valid_i = 1'b1;
			tick(1);
		end
		rx_valid_i = 1'b0;
		tick(3);
		chk(hex_first, HEX_START_MARK);
		chk(hex_cnt[7:0], 8'h02);
		bad(16'h7fff, 16'h8000);
	endtask
	task automatic t_auth;
		vec(8'h00, 8'h00, 8'h00);
		set_pw(16'hfeff, 16'hfef8, 8, 0);
		do_reset();
		run(CMD_READ, 0, 16'hfeff, 16'hfef8, 8, -1, 1);
		chk(status_blank_o, 0);
		run(CMD_SECURITY, 0, 16'hfeff, 16'hfef8, 8, -1, 1);
		chk(set_seen, 1);
		run(CMD_READ, 0, 16'hfeff, 16'hfef8, 8, 3, 0);
		chk(pw_error_o, 1);
		run(CMD_READ, 0, 16'hfeff, 16'hfef8, 8, -1, 0);
	endtask
	task automatic t_errors;
		set_pw(16'h9000, 16'ha000, 8, 0);
		u_flash.mem[16'hfe00] = 8'h07;
		bad(16'h7fff, 16'ha000);
		bad(16'hff00, 16'ha000);
		bad(16'hfe00, 16'ha000);
		bad(16'h9000, 16'hfef9);
		set_pw(16'h9000, 16'ha000, 8, 1);
		bad(16'h9000, 16'ha000);
	endtask
	task automatic t_lock;
		lock_nv_i = 1'b1;
		do_reset();
		run(CMD_READ, 0, 16'hfeff, 16'hfef8, 8, -1, 0);
		do_reset();
		debug_start_i = 1'b1;
		tick(1);
		debug_start_i = 1'b0;
		for (int t = 0; t < 400 && !idle_o; t++)
			tick(1);
		chk(idle_o, 1);
		u_flash.mem[DEBUG_OPT_ADDR] = 8'hff;
		do_reset();
		run(8'h00, 0, 16'hfeff, 16'hfef8, 8, -1, 1);
		do_reset();
		run(CMD_ERASE, 0, 16'hfeff, 16'hfef8, 8, -1, 0);
		do_reset();
		run(CMD_ERASE, 1, 16'hfeff, 16'hfef8, 8, -1, 1);
		chk(clr_seen, 1);
		lock_nv_i = 1'b0;
	endtask
	task automatic t_bypass;
		vec(8'h00, 8'h00, 8'h00);
		do_reset();
		run(CMD_READ, 0, 16'hfeff, 16'hfef8, 8, -1, 1);
		run(CMD_RAM_LOAD, 0, 16'hfeff, 16'hfef8, 8, -1, 1);
		vec(8'h00, 8'hff, 8'h00);
		run(CMD_ERASE, 1, 16'hfeff, 16'hfef8, 0, -1, 1);
		run(CMD_ERASE, 0, 16'hfeff, 16'hfef8, 0, -1, 0);
	endtask
	initial begin
		{reset_i, cmd_valid_i, ptr_valid_i, rx_valid_i, debug_start_i, par_mode_i} = 6'h01 << 5;
		{par_read_i, par_write_i, par_chip_erase_i, op_done_i, lock_nv_i} = 5'h0;
		{cmd_i, ptr_i, rx_data_i} = '0;
		lat = 4'h0;
		do_reset();
		t_par();
		t_blank();
		lat = 4'h3;
		t_auth();
		t_errors();
		t_lock();
		lat = 4'h0;
		t_bypass();
		print_verdict();
	end
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
`default_nettype wire
